// >>> tws_pkg.sv
package tws_pkg;
  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] ADR_UNIT = 8'h00;
  localparam logic [7:0] ADR_PRESC = 8'h04;
  localparam logic [7:0] ADR_MODE = 8'h08;
  localparam logic [7:0] ADR_DATA = 8'h0c;
  localparam logic [7:0] ADR_START = 8'h10;
  localparam logic [7:0] ADR_STOP = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_OUT = 8'h1c;
  localparam logic [7:0] ADR_FCLR = 8'h20;
  // Field positions.
  localparam int DATA_DIV_LSB = 9;
  localparam int FLAG_OVR_BIT = 2;
  // Reset values.
  localparam logic [3:0] PRESC_RST = 4'h0;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [2:0] OUT_RST = 3'h3;
  // Timing: half serial clock never below two system clocks (fclk/4).
  localparam logic [18:0] HALF_MIN = 19'h00002;
  localparam logic [3:0] PRESC_MAX = 4'hb;
  localparam int CLK_HZ = 10000000;

  // Channel mode fields.
  typedef struct packed {
    logic cont;
    logic len7;
    logic lsb_first;
    logic ckp;
    logic dap;
  } tws_mode_t;

  // Serial pins.
  typedef struct packed {
    logic sck;
    logic sdo;
    logic sdo_oe;
  } tws_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} tws_state_t;

  // Bit presented on the data line for the current shifter contents.
  function automatic logic tws_out_bit(input logic [7:0] sh, input tws_mode_t m);
    if (m.lsb_first) tws_out_bit = sh[0];
    else if (m.len7) tws_out_bit = sh[6];
    else tws_out_bit = sh[7];
  endfunction : tws_out_bit

  // Shifter contents after one bit has gone out.
  function automatic logic [7:0] tws_shift(input logic [7:0] sh, input tws_mode_t m);
    tws_shift = m.lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
  endfunction : tws_shift
endpackage : tws_pkg

// >>> tws_rate_gen.sv
`timescale 1ns/1ps
module tws_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [3:0] presc,
  input wire logic [6:0] divider,
  output logic tick
);
  logic [18:0] cnt_reg;
  logic [18:0] limit;
  logic [3:0] k;

  // Half period is (divider+1) * 2^k system clocks, clamped to the fastest legal rate.
  always_comb begin
    k = (presc > tws_pkg::PRESC_MAX) ? tws_pkg::PRESC_MAX : presc;
    limit = 19'({12'h000, divider} + 19'h00001) << k;
    if (limit < tws_pkg::HALF_MIN) limit = tws_pkg::HALF_MIN;
  end

  // Counter restarts whenever the engine is idle, so the first half is always full length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 19'h00000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 19'h00000;
      tick <= 1'b0;
    end else if (cnt_reg >= limit - 19'h00001) begin
      cnt_reg <= 19'h00000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 19'h00001;
      tick <= 1'b0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tick_spacing: assert property (tick |=> !tick)
    else $error("serial half period shorter than two clocks");
endmodule : tws_rate_gen

// >>> tws_master_tx.sv
`timescale 1ns/1ps
// Function
// - Words of 7 or 8 bits, MSB-first or LSB-first selectable.
// - Master generates the serial clock and drives data out.
// - Data phase 0: first bit appears together with first clock edge.
// - Data phase 1: first bit appears half a clock before clocking.
// - Clock polarity bit: 0 forward, 1 inverted serial clock.
// - Rate from fclk/4 down to fclk/(2*2^11*128).
// - Interrupt is transfer end (single) or buffer empty (continuous).
// - Writing 1 to start trigger sets channel enable status.
// - Writing data low byte starts transmission on an enabled channel.
// - After stop, pins hold last level until output register rewritten.
// - Flag clear register clears the overrun flag (bit 2).
// - Three-wire function only exists on designated channels.
// - One clock line plus separate input and output data lines.
// - Master only, transmit always; receive runs alongside.
// - Stop trigger self-clears once enable status reads 0.
// - Unit clock off: control writes ignored, reads return defaults.
// - Data register bits 15:9 hold the rate divider.
module tws_master_tx #(
  parameter bit HAS_THREE_WIRE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sdi,
  output tws_pkg::tws_pins_t pins,
  output logic serial_done_irq
);
  // ********************************
  // Register state
  // ********************************
  logic unit_clock_enable_reg;
  logic [3:0] presc_reg;
  tws_pkg::tws_mode_t mode_reg;
  logic [6:0] div_reg;
  logic en_reg;
  logic stop_reg;
  logic ovr_reg;
  logic data_idle_level_bit_reg;
  logic clock_idle_level_bit_reg;
  logic [7:0] buf_reg;
  logic buf_full_reg;
  logic [7:0] rx_reg;
  tws_pkg::tws_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] hp_reg;
  logic sdi_s1_reg;
  logic sdi_s2_reg;
  logic tick;
  logic acc;
  logic wr;
  logic last_hp;

  // Transfer qualifies only at the access edge where pready is high.
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign last_hp = (hp_reg == (mode_reg.len7 ? 4'hd : 4'hf));

  // ********************************
  // APB slave
  // ********************************
  // No wait state: the answer is built in setup so every output is a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr == tws_pkg::ADR_UNIT) begin
        prdata <= {31'h00000000, unit_clock_enable_reg};
      end else if (!unit_clock_enable_reg) begin
        // Defaults only while the unit clock is off.
        if (paddr == tws_pkg::ADR_OUT) prdata <= {29'h00000000, tws_pkg::OUT_RST};
        else if (paddr > tws_pkg::ADR_FCLR || paddr[1:0] != 2'h0) pslverr <= 1'b1;
      end else if (paddr == tws_pkg::ADR_PRESC) begin
        prdata <= {28'h0000000, presc_reg};
      end else if (paddr == tws_pkg::ADR_MODE) begin
        prdata <= {27'h0000000, mode_reg};
      end else if (paddr == tws_pkg::ADR_DATA) begin
        prdata <= {16'h0000, div_reg, 1'b0, rx_reg};
      end else if (paddr == tws_pkg::ADR_STOP) begin
        prdata <= {31'h00000000, stop_reg};
      end else if (paddr == tws_pkg::ADR_STAT) begin
        prdata <= {25'h0000000, stop_reg, ovr_reg, 2'h0, buf_full_reg,
                   state_reg != tws_pkg::ST_IDLE, en_reg};
      end else if (paddr == tws_pkg::ADR_OUT) begin
        prdata <= {29'h00000000, pins.sdo_oe, clock_idle_level_bit_reg,
                   data_idle_level_bit_reg};
      end else if (paddr == tws_pkg::ADR_START || paddr == tws_pkg::ADR_FCLR) begin
        prdata <= 32'h00000000;
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ********************************
  // Control registers
  // ********************************
  // The unit enable is always writable; the rest only while the unit is clocked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_clock_enable_reg <= 1'b0;
      presc_reg <= tws_pkg::PRESC_RST;
      mode_reg <= tws_pkg::MODE_RST;
      div_reg <= tws_pkg::DIV_RST;
      data_idle_level_bit_reg <= tws_pkg::OUT_RST[0];
      clock_idle_level_bit_reg <= tws_pkg::OUT_RST[1];
    end else if (wr) begin
      if (paddr == tws_pkg::ADR_UNIT && pstrb[0]) begin
        unit_clock_enable_reg <= pwdata[0];
      end else if (!unit_clock_enable_reg) begin
        unit_clock_enable_reg <= 1'b0;
      end else if (paddr == tws_pkg::ADR_PRESC && pstrb[0]) begin
        presc_reg <= pwdata[3:0];
      end else if (paddr == tws_pkg::ADR_MODE && pstrb[0]) begin
        mode_reg <= pwdata[4:0];
      end else if (paddr == tws_pkg::ADR_DATA && pstrb[1]) begin
        div_reg <= pwdata[15:tws_pkg::DATA_DIV_LSB];
      end else if (paddr == tws_pkg::ADR_OUT && pstrb[0] && !en_reg) begin
        data_idle_level_bit_reg <= pwdata[0];
        clock_idle_level_bit_reg <= pwdata[1];
      end
    end
  end

  // Channel enable: start sets it, stop or unit shutdown clears it; start wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
    end else if (wr && unit_clock_enable_reg && HAS_THREE_WIRE && pstrb[0]
                 && paddr == tws_pkg::ADR_START && pwdata[0]) begin
      en_reg <= 1'b1;
    end else if (stop_reg || !unit_clock_enable_reg) begin
      en_reg <= 1'b0;
    end
  end

  // Stop trigger stays visible until enable status has dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_reg <= 1'b0;
    end else if (wr && unit_clock_enable_reg && pstrb[0]
                 && paddr == tws_pkg::ADR_STOP && pwdata[0]) begin
      stop_reg <= 1'b1;
    end else if (!en_reg) begin
      stop_reg <= 1'b0;
    end
  end

  // Transmit buffer; a write over a full buffer replaces it and marks overrun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= 8'h00;
      buf_full_reg <= 1'b0;
    end else if (wr && unit_clock_enable_reg && en_reg && pstrb[0]
                 && paddr == tws_pkg::ADR_DATA) begin
      buf_reg <= pwdata[7:0];
      buf_full_reg <= 1'b1;
    end else if (!en_reg || state_reg == tws_pkg::ST_IDLE) begin
      buf_full_reg <= 1'b0;
    end
  end

  // Overrun flag: a fresh event in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_reg <= 1'b0;
    end else if (wr && unit_clock_enable_reg && en_reg && pstrb[0] && buf_full_reg
                 && paddr == tws_pkg::ADR_DATA && state_reg != tws_pkg::ST_IDLE) begin
      ovr_reg <= 1'b1;
    end else if (wr && unit_clock_enable_reg && paddr == tws_pkg::ADR_FCLR
                 && pwdata[tws_pkg::FLAG_OVR_BIT]) begin
      ovr_reg <= 1'b0;
    end
  end

  // ********************************
  // Serial engine
  // ********************************
  tws_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_reg != tws_pkg::ST_IDLE),
    .presc(presc_reg),
    .divider(div_reg),
    .tick(tick)
  );

  // The data input is asynchronous to pclk, so two flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      sdi_s1_reg <= sdi;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  // Receive shifter samples on every trailing clock edge alongside transmit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= 8'h00;
    end else if (state_reg == tws_pkg::ST_SHIFT && tick && !hp_reg[0]) begin
      rx_reg <= mode_reg.lsb_first ? {sdi_s2_reg, rx_reg[7:1]}
                                   : {rx_reg[6:0], sdi_s2_reg};
    end
  end

  // Sequencer, pins and the event pulse. Even half periods have the clock
  // active, odd ones inactive; the pins hold whatever was driven last.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tws_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      hp_reg <= 4'h0;
      pins <= '{sck: tws_pkg::OUT_RST[1], sdo: tws_pkg::OUT_RST[0], sdo_oe: 1'b0};
      serial_done_irq <= 1'b0;
    end else begin
      serial_done_irq <= 1'b0;
      if (wr && unit_clock_enable_reg && paddr == tws_pkg::ADR_OUT && pstrb[0]
          && !en_reg) begin
        pins.sdo_oe <= pwdata[2];
      end
      if (!en_reg) begin
        // Aborted or stopped: levels stay until the output register is written.
        state_reg <= tws_pkg::ST_IDLE;
        if (wr && unit_clock_enable_reg && paddr == tws_pkg::ADR_OUT && pstrb[0]) begin
          pins.sdo <= pwdata[0];
          pins.sck <= pwdata[1];
        end
      end else begin
        case (state_reg)
          tws_pkg::ST_IDLE: begin
            if (buf_full_reg) begin
              shift_reg <= buf_reg;
              hp_reg <= 4'h0;
              pins.sdo <= tws_pkg::tws_out_bit(buf_reg, mode_reg);
              serial_done_irq <= mode_reg.cont;
              if (mode_reg.dap) begin
                state_reg <= tws_pkg::ST_LEAD;
              end else begin
                state_reg <= tws_pkg::ST_SHIFT;
                pins.sck <= mode_reg.ckp;
              end
            end
          end
          tws_pkg::ST_LEAD: begin
            if (tick) begin
              state_reg <= tws_pkg::ST_SHIFT;
              pins.sck <= mode_reg.ckp;
            end
          end
          tws_pkg::ST_SHIFT: begin
            if (tick) begin
              hp_reg <= hp_reg + 4'h1;
              if (!hp_reg[0]) begin
                pins.sck <= !mode_reg.ckp;
                if (mode_reg.dap && !last_hp && hp_reg != (mode_reg.len7 ? 4'hc : 4'he)) begin
                  shift_reg <= tws_pkg::tws_shift(shift_reg, mode_reg);
                  pins.sdo <= tws_pkg::tws_out_bit(
                      tws_pkg::tws_shift(shift_reg, mode_reg), mode_reg);
                end
              end else if (last_hp) begin
                state_reg <= tws_pkg::ST_IDLE;
                serial_done_irq <= !mode_reg.cont;
              end else begin
                pins.sck <= mode_reg.ckp;
                if (!mode_reg.dap) begin
                  shift_reg <= tws_pkg::tws_shift(shift_reg, mode_reg);
                  pins.sdo <= tws_pkg::tws_out_bit(
                      tws_pkg::tws_shift(shift_reg, mode_reg), mode_reg);
                end
              end
            end
          end
          default: state_reg <= tws_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stop_self_clear: assert property (stop_reg && !en_reg |=> !stop_reg)
    else $error("stop trigger did not self-clear");
  a_start_sets_enable: assert property (wr && unit_clock_enable_reg && pstrb[0]
      && paddr == tws_pkg::ADR_START && pwdata[0] |=> en_reg)
    else $error("start trigger did not enable channel");
  a_data_starts_shift: assert property (wr && unit_clock_enable_reg && en_reg && pstrb[0]
      && paddr == tws_pkg::ADR_DATA && state_reg == tws_pkg::ST_IDLE && !stop_reg
      |=> ##1 state_reg != tws_pkg::ST_IDLE)
    else $error("data write did not start a transfer");
  a_lead_clock_idle: assert property (state_reg == tws_pkg::ST_LEAD
      |-> pins.sck == !mode_reg.ckp)
    else $error("clock moved during data lead");
  a_dap0_coincide: assert property (state_reg == tws_pkg::ST_SHIFT
      && $past(state_reg) == tws_pkg::ST_IDLE |-> pins.sck == mode_reg.ckp)
    else $error("first clock edge not with first bit");
  a_done_one_cycle: assert property (serial_done_irq |=> !serial_done_irq)
    else $error("event pulse longer than one cycle");
  a_pins_hold: assert property (!en_reg && !$past(en_reg) && !wr
      |=> $stable(pins))
    else $error("pins changed while stopped");
  a_off_reads_default: assert property (psel && !penable && !pready
      && !unit_clock_enable_reg && paddr == tws_pkg::ADR_MODE |=> prdata == 32'h00000000)
    else $error("read with unit off returned non default");
  a_flag_clear: assert property (wr && unit_clock_enable_reg && paddr == tws_pkg::ADR_FCLR
      && pwdata[tws_pkg::FLAG_OVR_BIT] && paddr != tws_pkg::ADR_DATA |=> !ovr_reg)
    else $error("flag clear did not clear overrun");
endmodule : tws_master_tx

// >>> tws_slave_model.sv
`timescale 1ns/1ps
module tws_slave_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ckp,
  input wire tws_pkg::tws_pins_t pins,
  output logic sdi
);
  bit bits[$];
  int half_cnt;
  int last_half;
  logic sck_q;
  logic sdo_q;

  // ********************************
  // Receiver
  // ********************************
  // Bits are taken from the level held over the half period that just closed, so a data
  // change on the same edge as the closing clock edge cannot slip in.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      sdo_q <= 1'b1;
      half_cnt <= 0;
      last_half <= 0;
      sdi <= 1'b0;
    end else begin
      sck_q <= pins.sck;
      sdo_q <= pins.sdo;
      half_cnt <= half_cnt + 1;
      if (pins.sck !== sck_q) begin
        last_half <= half_cnt;
        half_cnt <= 1;
      end
      if (sck_q === ckp && pins.sck === ~ckp) bits.push_back(sdo_q);
      // Nothing is sent back, so the input line flips every cycle to expose stale use.
      sdi <= ~sdi;
    end
  end
endmodule : tws_slave_model

// >>> tws_master_tx_tb.sv
`timescale 1ns/1ps
module tws_master_tx_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sdi, irq, ckp, slv;
  logic [7:0] paddr;
  logic [7:0] seed;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd;
  tws_pkg::tws_pins_t pins, snap;
  tws_pkg::tws_mode_t m;
  logic [7:0] exp_q[$];
  int error_cnt, checks, irq_cnt;

  tws_master_tx u_tws_master_tx (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sdi(sdi), .pins(pins), .serial_done_irq(irq)
  );
  tws_slave_model u_tws_slave_model (
    .pclk(pclk), .presetn(presetn), .ckp(ckp), .pins(pins), .sdi(sdi)
  );

  // ********************************
  // Clock and event counting
  // ********************************
  // The clock runs at 10 MHz.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // High cycles are counted, so a pulse that stands too long shows as an extra count.
  always @(posedge pclk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Requests are held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask : rdc

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Bits are gathered in wire order and compared with the oldest queued word.
  task automatic chk_word(input tws_pkg::tws_mode_t mm);
    logic [7:0] got;
    got = 8'h00;
    for (int i = 0; i < (mm.len7 ? 7 : 8); i++) begin
      if (u_tws_slave_model.bits.size() > 0) begin
        if (mm.lsb_first) got[i] = u_tws_slave_model.bits.pop_front();
        else got = {got[6:0], u_tws_slave_model.bits.pop_front()};
      end
    end
    chk({24'h0, got}, {24'h0, exp_q.pop_front()});
  endtask : chk_word

  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (u_tws_slave_model.bits.size() < n && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) begin
      error_cnt++;
      close_out();
    end
    repeat (4) @(posedge pclk);
  endtask : wait_bits

  task automatic setup(input tws_pkg::tws_mode_t mm);
    ckp <= mm.ckp;
    apb(1'b1, tws_pkg::ADR_OUT, {30'h0, ~mm.ckp, 1'b1});
    apb(1'b1, tws_pkg::ADR_MODE, {27'h0, mm});
    apb(1'b1, tws_pkg::ADR_FCLR, 32'h4);
    apb(1'b1, tws_pkg::ADR_OUT, {29'h0, 1'b1, ~mm.ckp, 1'b1});
    apb(1'b1, tws_pkg::ADR_START, 32'h1);
    rdc(tws_pkg::ADR_STAT, 32'h3, 32'h1);
    // Idle level changes above may look like a clock edge to the slave.
    u_tws_slave_model.bits.delete();
  endtask : setup

  task automatic send(input tws_pkg::tws_mode_t mm, input logic [6:0] dv, input bit look);
    logic fb;
    seed = lfsr(seed);
    fb = mm.lsb_first ? seed[0] : (mm.len7 ? seed[6] : seed[7]);
    exp_q.push_back(mm.len7 ? {1'b0, seed[6:0]} : seed);
    apb(1'b1, tws_pkg::ADR_DATA, {16'h0, dv, 1'b0, seed});
    if (look) begin
      @(posedge pclk);
      #1;
      chk({30'h0, pins.sck, pins.sdo}, {30'h0, mm.ckp ^ mm.dap, fb});
    end
  endtask : send

  task automatic halt;
    apb(1'b1, tws_pkg::ADR_STOP, 32'h1);
    repeat (2) @(posedge pclk);
    rdc(tws_pkg::ADR_STAT, 32'h41, 32'h0);
    rdc(tws_pkg::ADR_STOP, 32'h1, 32'h0);
  endtask : halt

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ckp = 1'b0;
    seed = 8'h2b;
    error_cnt = 0;
    checks = 0;
    irq_cnt = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({29'h0, pins}, 32'h6);
    apb(1'b1, tws_pkg::ADR_MODE, 32'h1f);
    rdc(tws_pkg::ADR_OUT, 32'hffffffff, 32'h3);
    rdc(tws_pkg::ADR_MODE, 32'hffffffff, 32'h0);
    apb(1'b1, tws_pkg::ADR_UNIT, 32'h1);
    repeat (4) @(posedge pclk);
    apb(1'b1, tws_pkg::ADR_PRESC, 32'h0);
    rdc(tws_pkg::ADR_MODE, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, slv}, 32'h1);
    $display("test reset and refusal done");
    // Every phase, polarity, order and length in single mode at the fastest rate.
    for (int k = 0; k < 16; k++) begin
      m = tws_pkg::tws_mode_t'(k[4:0]);
      setup(m);
      send(m, 7'h00, 1'b1);
      wait_bits(m.len7 ? 7 : 8);
      chk(irq_cnt, k + 1);
      chk(u_tws_slave_model.last_half, 32'h2);
      chk_word(m);
      halt;
    end
    $display("test single modes done");
    // Slow rate, then a stop in mid-word: the pins freeze until rewritten.
    m = tws_pkg::tws_mode_t'(5'h00);
    apb(1'b1, tws_pkg::ADR_PRESC, 32'h1);
    setup(m);
    send(m, 7'h02, 1'b0);
    repeat (40) @(posedge pclk);
    chk(u_tws_slave_model.last_half, 32'h6);
    rdc(tws_pkg::ADR_DATA, 32'hfe00, 32'h400);
    apb(1'b1, tws_pkg::ADR_STOP, 32'h1);
    repeat (2) @(posedge pclk);
    snap = pins;
    repeat (20) @(posedge pclk);
    chk({29'h0, pins}, {29'h0, snap});
    apb(1'b1, tws_pkg::ADR_OUT, 32'h6);
    repeat (2) @(posedge pclk);
    chk({29'h0, pins}, 32'h5);
    exp_q.delete();
    $display("test rate and abort done");
    // Continuous mode: queue a word, overrun the buffer, clear the flag.
    apb(1'b1, tws_pkg::ADR_PRESC, 32'h0);
    m = tws_pkg::tws_mode_t'(5'h10);
    setup(m);
    send(m, 7'h00, 1'b0);
    send(m, 7'h00, 1'b0);
    rdc(tws_pkg::ADR_STAT, 32'h27, 32'h7);
    send(m, 7'h00, 1'b0);
    exp_q.delete(1);
    rdc(tws_pkg::ADR_STAT, 32'h20, 32'h20);
    apb(1'b1, tws_pkg::ADR_FCLR, 32'h4);
    rdc(tws_pkg::ADR_STAT, 32'h20, 32'h0);
    wait_bits(16);
    chk(irq_cnt, 18);
    chk_word(m);
    chk_word(m);
    chk(u_tws_slave_model.bits.size(), 0);
    halt;
    $display("test continuous done");
    close_out();
  end
endmodule : tws_master_tx_tb
